/* rtl/hlt8_timer.sv */
// Eight-bit limit timer with prescaler, postscaler and AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hlt8_timer (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // AXI4-Lite write address
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  // AXI4-Lite write data
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  // AXI4-Lite read address
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  // Clock sources, codes 2 to 12, bit n is code n
  input  wire logic [12:2] CLK_SRC_IN,
  // External reset sources, codes 0 to 14
  input  wire logic [14:0] RST_SRC_IN,
  // Processor sleep, same clock domain
  input  wire logic        SLEEP,
  // To compare unit and system
  output logic [7:0]       COUNT_VALUE,
  output logic             PWM_START,
  output logic             POSTSCALED_OUT,
  output logic             TIMER_INT_FLAG,
  output logic             OSC_KEEP_ALIVE
);

  logic [3:0]  clk_sel_q;
  logic [7:0]  control_q;
  logic [7:0]  limit_q;
  logic [3:0]  rst_sel_q;
  logic [7:0]  period_q;
  logic [7:0]  count_q;
  logic        flag_q;
  logic [12:2] src_s1_q, src_s2_q, src_s3_q;
  logic [14:0] ers_s1_q, ers_s2_q;
  logic        ers_q;
  localparam int ON_SYNC_LEN = hlt8_pkg::ON_SYNC_LEN;
  logic [1:0]  instr_q;
  logic [ON_SYNC_LEN-1:0] on_sync_q;
  logic [6:0]  pre_q;
  logic        pend_q;
  logic [3:0]  post_q;
  hlt8_pkg::hlt8_state_t state_q;
  logic        aw_got_q, w_got_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        w_strb_q;

  wire logic       on_q     = control_q[hlt8_pkg::CTL_ON_BIT];
  wire logic [2:0] pre_sel  = control_q[hlt8_pkg::CTL_PRE_LSB +: 3];
  wire logic [3:0] post_sel = control_q[hlt8_pkg::CTL_POST_LSB +: 4];
  wire logic       prescaler_sync_enable    = limit_q[hlt8_pkg::LIM_PRESCALER_SYNC_ENABLE];
  wire logic       clock_polarity    = limit_q[hlt8_pkg::LIM_CLOCK_POLARITY];
  wire logic       enable_sync_to_timer_clock   = limit_q[hlt8_pkg::LIM_ENABLE_SYNC_TO_TIMER_CLOCK];
  wire logic [4:0] mode     = limit_q[hlt8_pkg::LIM_MODE_LSB +: 5];

  // Register index decode, shared by read and write paths
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      hlt8_pkg::ADDR_CLKSEL:  reg_index = 3'h1;
      hlt8_pkg::ADDR_CONTROL: reg_index = 3'h2;
      hlt8_pkg::ADDR_LIMIT:   reg_index = 3'h3;
      hlt8_pkg::ADDR_RSTSEL:  reg_index = 3'h4;
      hlt8_pkg::ADDR_PERIOD:  reg_index = 3'h5;
      hlt8_pkg::ADDR_COUNT:   reg_index = 3'h6;
      hlt8_pkg::ADDR_STATUS:  reg_index = 3'h7;
      default:                reg_index = 3'h0;
    endcase
  endfunction : reg_index

  // Source synchronisers; first stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    src_s1_q <= CLK_SRC_IN;
    src_s2_q <= src_s1_q;
    src_s3_q <= src_s2_q;
    ers_s1_q <= RST_SRC_IN;
    ers_s2_q <= ers_s1_q;
  end

  // Reserved reset code reads as a constant low
  wire logic ers_now = (rst_sel_q <= hlt8_pkg::RS_LAST) ? ers_s2_q[rst_sel_q] : 1'b0;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ers_q <= 1'b0;
    end else begin
      ers_q <= ers_now;
    end
  end
  wire logic ers_rise = ers_now & ~ers_q;
  wire logic ers_fall = ~ers_now & ers_q;

  // Instruction clock phase, one in four system clocks
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      instr_q <= 2'h0;
    end else begin
      instr_q <= instr_q + 2'h1;
    end
  end
  wire logic instr_ph = (instr_q == hlt8_pkg::INSTR_DIV);

  // Input clock edge select; core clocks stop in sleep
  logic src_edge;
  always_comb begin
    src_edge = 1'b0;
    if (clk_sel_q == hlt8_pkg::CS_INSTR) begin
      src_edge = instr_ph & ~SLEEP;
    end else if (clk_sel_q == hlt8_pkg::CS_SYSTEM) begin
      src_edge = ~SLEEP;
    end else if (clk_sel_q <= hlt8_pkg::CS_LAST) begin
      src_edge = clock_polarity ? (~src_s2_q[clk_sel_q] & src_s3_q[clk_sel_q])
                       : (src_s2_q[clk_sel_q] & ~src_s3_q[clk_sel_q]);
    end
  end
  // Reserved codes leave src_edge low, so nothing counts
  wire logic in_edge = src_edge & ~(SLEEP & prescaler_sync_enable);

  // Enable synchronised to the input clock when asked
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      on_sync_q <= '0;
    end else if (in_edge) begin
      on_sync_q <= {on_sync_q[ON_SYNC_LEN-2:0], on_q};
    end
  end
  wire logic on_eff = enable_sync_to_timer_clock ? on_sync_q[ON_SYNC_LEN-1] : on_q;

  // Prescaler
  wire logic [6:0] pre_mask = 7'((8'h01 << pre_sel) - 8'h01);
  wire logic       pre_tick = in_edge & ((pre_q & pre_mask) == pre_mask);
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !on_eff) begin
      pre_q <= 7'h00;
    end else if (in_edge) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // Ticks held until the instruction phase so count reads stay stable
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !on_eff || !prescaler_sync_enable) begin
      pend_q <= 1'b0;
    end else if (instr_ph) begin
      pend_q <= 1'b0;
    end else if (pre_tick) begin
      pend_q <= 1'b1;
    end
  end
  wire logic tick = prescaler_sync_enable ? ((pend_q | pre_tick) & instr_ph) : pre_tick;

  // Mode decode
  wire logic is_mono  = (mode == hlt8_pkg::MODE_MONO_R) || (mode == hlt8_pkg::MODE_MONO_F) ||
                        (mode == hlt8_pkg::MODE_MONO_RF);
  wire logic is_level = (mode == hlt8_pkg::MODE_LVL_LO) || (mode == hlt8_pkg::MODE_LVL_HI);
  wire logic mono_edge = ((mode == hlt8_pkg::MODE_MONO_R)  & ers_rise) |
                         ((mode == hlt8_pkg::MODE_MONO_F)  & ers_fall) |
                         ((mode == hlt8_pkg::MODE_MONO_RF) & (ers_rise | ers_fall));
  wire logic rst_level = (mode == hlt8_pkg::MODE_LVL_LO) ? ~ers_now : ers_now;
  wire logic match     = tick & (count_q == period_q);

  // Run state and drive start
  wire logic mono_start  = is_mono & on_eff & (state_q == hlt8_pkg::HLT8_IDLE) & mono_edge;
  wire logic level_start = is_level & on_eff & ~rst_level & (state_q == hlt8_pkg::HLT8_IDLE);
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !on_eff) begin
      state_q <= hlt8_pkg::HLT8_IDLE;
    end else begin
      unique case (state_q)
        hlt8_pkg::HLT8_IDLE: begin
          if (mono_start || level_start) begin
            state_q <= hlt8_pkg::HLT8_RUN;
          end
        end
        hlt8_pkg::HLT8_RUN: begin
          if (is_level && rst_level) begin
            state_q <= hlt8_pkg::HLT8_IDLE;
          end else if (match && (is_mono || is_level)) begin
            state_q <= hlt8_pkg::HLT8_IDLE;
          end
        end
      endcase
    end
  end

  // Drive start pulse; edges while running are not seen
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PWM_START <= 1'b0;
    end else begin
      PWM_START <= mono_start | level_start;
    end
  end

  wire logic advance = is_mono  ? (state_q == hlt8_pkg::HLT8_RUN) :
                       is_level ? (state_q == hlt8_pkg::HLT8_RUN) & ~rst_level :
                       on_eff;
  wire logic match_go = match & advance;

  // Write channel bookkeeping: address and data taken in either order
  wire logic wr_go = aw_got_q & w_got_q & ~S_AXI_BVALID;
  wire logic [2:0] wr_idx = reg_index(aw_addr_q);
  wire logic wr_en = wr_go & w_strb_q;

  // Count register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_q <= 8'h00;
    end else if (wr_en && wr_idx == 3'h6) begin
      count_q <= w_data_q[7:0];
    end else if (is_level && (rst_level || !on_eff)) begin
      count_q <= 8'h00;
    end else if (tick && advance) begin
      count_q <= match ? 8'h00 : count_q + 8'h01;
    end
  end

  // Postscaler and its pulse
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !on_eff) begin
      post_q         <= 4'h0;
      POSTSCALED_OUT <= 1'b0;
    end else begin
      POSTSCALED_OUT <= 1'b0;
      if (match_go) begin
        if (post_q == post_sel) begin
          post_q         <= 4'h0;
          POSTSCALED_OUT <= 1'b1;
        end else begin
          post_q <= post_q + 4'h1;
        end
      end
    end
  end
  wire logic post_evt = match_go & (post_q == post_sel);

  // Control register; hardware clear loses to a software write
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      control_q <= hlt8_pkg::RST_CONTROL;
    end else if (wr_en && wr_idx == 3'h2) begin
      control_q <= w_data_q[7:0];
    end else if (match_go && is_level) begin
      control_q[hlt8_pkg::CTL_ON_BIT] <= 1'b0;
    end
  end

  // Other software registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      clk_sel_q <= hlt8_pkg::RST_CLKSEL[3:0];
      limit_q   <= hlt8_pkg::RST_LIMIT;
      rst_sel_q <= hlt8_pkg::RST_RSTSEL[3:0];
      period_q  <= hlt8_pkg::RST_PERIOD;
    end else if (wr_en) begin
      unique case (wr_idx)
        3'h1:    clk_sel_q <= w_data_q[3:0];
        3'h3:    limit_q   <= w_data_q[7:0];
        3'h4:    rst_sel_q <= w_data_q[3:0];
        3'h5:    period_q  <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // Period-match flag; a new event beats a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flag_q <= 1'b0;
    end else if (post_evt) begin
      flag_q <= 1'b1;
    end else if (wr_en && wr_idx == 3'h7 && w_data_q[hlt8_pkg::STAT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // AXI write path
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= hlt8_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_got_q & ~S_AXI_AWREADY & S_AXI_AWVALID & ~S_AXI_BVALID;
      S_AXI_WREADY  <= ~w_got_q & ~S_AXI_WREADY & S_AXI_WVALID & ~S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q  <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_idx == 3'h0) ? hlt8_pkg::RESP_SLVERR : hlt8_pkg::RESP_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI read path; unimplemented bits read zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_index(S_AXI_ARADDR))
      3'h1:    rd_byte = {4'h0, clk_sel_q};
      3'h2:    rd_byte = control_q;
      3'h3:    rd_byte = limit_q;
      3'h4:    rd_byte = {4'h0, rst_sel_q};
      3'h5:    rd_byte = period_q;
      3'h6:    rd_byte = count_q;
      3'h7:    rd_byte = {7'h00, flag_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= hlt8_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h00_0000, rd_byte};
        S_AXI_RRESP  <= (reg_index(S_AXI_ARADDR) == 3'h0) ? hlt8_pkg::RESP_SLVERR : hlt8_pkg::RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Status outputs; oscillator kept awake only if the timer may run in sleep
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      COUNT_VALUE    <= 8'h00;
      TIMER_INT_FLAG <= 1'b0;
      OSC_KEEP_ALIVE <= 1'b0;
    end else begin
      COUNT_VALUE    <= count_q;
      TIMER_INT_FLAG <= flag_q;
      OSC_KEEP_ALIVE <= on_q & ~prescaler_sync_enable & ((clk_sel_q == hlt8_pkg::CS_HFOSC) ||
                        (clk_sel_q == hlt8_pkg::CS_LFOSC) || (clk_sel_q == hlt8_pkg::CS_MFOSC));
    end
  end

endmodule : hlt8_timer
`default_nettype wire

/* include/hlt8_pkg.sv */
// Constants, register map and mode codes of the 8-bit limit timer
// Function
// - Monostable modes start on selected edge, halt at match
// - Monostable drive starts with edge, not at match
// - Edges during monostable run leave drive alone
// - Level one-shot holds reset at selected level
// - Level one-shot match resets count, clears enable
// - Level one-shot drive starts on whichever starts count
// - Synced prescaler: timer frozen during sleep
// - Unsynced prescaler runs in sleep on clock codes 2 to 12; oscillator kept
// - Four-bit clock source select, top codes reserved
// - Enable low resets prescaler, postscaler, state
// - Prescale divides by two to the code
// - Postscale divides period matches by code plus one
// - Prescaler sync aligns ticks to instruction clock
// - Polarity bit chooses falling or rising edge
// - Enable sync delays start two input clocks
// - Default modes run with enable, keep count
// - Clock after period match clears count
// - Five-bit mode field selects control mode
// - Four-bit reset source select, code 1111 reserved
// - Software gate mode counts while enabled
package hlt8_pkg;
  localparam logic [7:0] ADDR_CLKSEL  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_LIMIT   = 8'h08;
  localparam logic [7:0] ADDR_RSTSEL  = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD  = 8'h10;
  localparam logic [7:0] ADDR_COUNT   = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] RST_CLKSEL   = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_LIMIT    = 8'h00;
  localparam logic [7:0] RST_RSTSEL   = 8'h00;
  localparam logic [7:0] RST_PERIOD   = 8'hFF;
  localparam int         CTL_ON_BIT   = 7;
  localparam int         CTL_PRE_LSB  = 4;
  localparam int         CTL_POST_LSB = 0;
  localparam int         LIM_PRESCALER_SYNC_ENABLE    = 7;
  localparam int         LIM_CLOCK_POLARITY    = 6;
  localparam int         LIM_ENABLE_SYNC_TO_TIMER_CLOCK   = 5;
  localparam int         LIM_MODE_LSB = 0;
  localparam int         STAT_FLAG    = 0;
  localparam logic [3:0] CS_INSTR     = 4'h0;
  localparam logic [3:0] CS_SYSTEM    = 4'h1;
  localparam logic [3:0] CS_HFOSC     = 4'h2;
  localparam logic [3:0] CS_LFOSC     = 4'h3;
  localparam logic [3:0] CS_MFOSC     = 4'h5;
  localparam logic [3:0] CS_LAST      = 4'hC;
  localparam logic [3:0] RS_LAST      = 4'hE;
  localparam logic [4:0] MODE_SW_GATE = 5'h00;
  localparam logic [4:0] MODE_MONO_R  = 5'h11;
  localparam logic [4:0] MODE_MONO_F  = 5'h12;
  localparam logic [4:0] MODE_MONO_RF = 5'h13;
  localparam logic [4:0] MODE_LVL_LO  = 5'h16;
  localparam logic [4:0] MODE_LVL_HI  = 5'h17;
  localparam logic [1:0] INSTR_DIV    = 2'h3;
  localparam int         ON_SYNC_LEN  = 2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {HLT8_IDLE, HLT8_RUN} hlt8_state_t;
endpackage : hlt8_pkg

/* tb/hlt8_timer_properties.sv */
// Port-level checks of the eight-bit limit timer
`timescale 1ns/1ps
`default_nettype none
module hlt8_timer_properties (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  // Timer outputs
  input wire logic [7:0]  COUNT_VALUE,
  input wire logic        PWM_START,
  input wire logic        POSTSCALED_OUT,
  input wire logic        TIMER_INT_FLAG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Address and data are parked first, so the response comes two edges after the handshake
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response missing");
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not retired");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response missing");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("address ready too long");
  // Bus writes may load the count, so the cycle after a response is exempt
  a_count_step: assert property ($changed(COUNT_VALUE) && !$past(S_AXI_BVALID) |->
    COUNT_VALUE == 8'h00 || COUNT_VALUE == $past(COUNT_VALUE) + 8'h01)
    else $error("count jumped");
  a_post_flag: assert property (POSTSCALED_OUT |-> ##[1:3] TIMER_INT_FLAG)
    else $error("flag missing after postscaled pulse");
  a_start_pulse: assert property (PWM_START |=> !PWM_START)
    else $error("start pulse too long");
  c_start: cover property (PWM_START);
  c_post: cover property (POSTSCALED_OUT);
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == hlt8_pkg::RESP_SLVERR);
endmodule : hlt8_timer_properties
bind hlt8_timer hlt8_timer_properties chk_u (.CLK_SYS, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_RDATA, .COUNT_VALUE, .PWM_START, .POSTSCALED_OUT, .TIMER_INT_FLAG);
`default_nettype wire

/* tb/hlt8_partner.sv */
// Far side: external reset source and a compare unit fed by the timer
`timescale 1ns/1ps
`default_nettype none
module hlt8_partner (
  // Clock
  input  wire logic        clk,
  // From the timer
  input  wire logic        pwm_start,
  input  wire logic [7:0]  count_value,
  // From the test sequence
  input  wire logic        ers_level,
  input  wire logic [7:0]  width_value,
  // To the timer; compare drive output
  output logic      [14:0] rst_src,
  output logic             pwm_out
);
  // Only the mapped-pin source moves; others idle low
  assign rst_src = {14'h0000, ers_level};
  // Drive set by the start pulse, cleared at width match
  always_ff @(posedge clk) begin
    if (pwm_start) begin
      pwm_out <= 1'b1;
    end else if (count_value == width_value) begin
      pwm_out <= 1'b0;
    end
  end
endmodule : hlt8_partner
`default_nettype wire

/* tb/hlt8_timer_tb_top.sv */
// Register-level test bench of the eight-bit limit timer
`timescale 1ns/1ps
`default_nettype none
module hlt8_timer_tb_top;
  localparam logic [7:0] r_ctl = hlt8_pkg::ADDR_CONTROL;
  localparam logic [7:0] r_lim = hlt8_pkg::ADDR_LIMIT;
  localparam logic [7:0] r_cnt = hlt8_pkg::ADDR_COUNT;
  localparam logic [7:0] r_clk = hlt8_pkg::ADDR_CLKSEL;
  localparam logic [7:0] r_per = hlt8_pkg::ADDR_PERIOD;
  localparam logic [7:0] r_sta = hlt8_pkg::ADDR_STATUS;
  logic        CLK_SYS, RST_N, SLEEP, ers, xclk, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic        PWM_START, POSTSCALED_OUT, TIMER_INT_FLAG, OSC_KEEP_ALIVE;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, COUNT_VALUE;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d0;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [14:0] RST_SRC_IN;
  int          fails = 0, n_checks = 0, cyc = 0, last_t = 0, gap = 0, np = 0, ns = 0, s, t;
  logic [7:0]  ra[7] = '{r_clk, r_ctl, r_lim, hlt8_pkg::ADDR_RSTSEL, r_per, r_cnt, r_sta};
  logic [7:0]  rv[7] = '{hlt8_pkg::RST_CLKSEL, hlt8_pkg::RST_CONTROL, hlt8_pkg::RST_LIMIT,
                         hlt8_pkg::RST_RSTSEL, hlt8_pkg::RST_PERIOD, 8'h00, 8'h00};
  // Clock code, prescale, postscale per nibble
  logic [11:0] pt[6] = '{12'h100, 12'h112, 12'h131, 12'h10F, 12'h170, 12'h000};
  logic [4:0]  mm[3] = '{hlt8_pkg::MODE_MONO_R, hlt8_pkg::MODE_MONO_F, hlt8_pkg::MODE_MONO_RF};

  hlt8_timer dut_u (
    .CLK_SYS, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_AWPROT(3'h0), .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_ARPROT(3'h0), .S_AXI_RVALID, .S_AXI_RREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .CLK_SRC_IN({11{xclk}}), .RST_SRC_IN, .SLEEP, .COUNT_VALUE, .PWM_START,
    .POSTSCALED_OUT, .TIMER_INT_FLAG, .OSC_KEEP_ALIVE
  );
  hlt8_partner far_u (
    .clk(CLK_SYS), .pwm_start(PWM_START), .count_value(COUNT_VALUE), .ers_level(ers),
    .width_value(8'h03), .rst_src(RST_SRC_IN), .pwm_out()
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (RST_N && POSTSCALED_OUT) begin
      gap <= cyc - last_t;
      last_t <= cyc;
      np <= np + 1;
    end
    if (RST_N && PWM_START) ns <= ns + 1;
  end

  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_n(ref int c, input int tg);
    int n;
    n = 0;
    while (c < tg && n < 5000) begin
      @(posedge CLK_SYS);
      n++;
    end
    chk("wait", 32'h0, {31'h0, n >= 5000});
    if (n >= 5000) wrap_up();
  endtask : wait_n

  // Response ready offered with the request; one idle edge between calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = hlt8_pkg::RESP_OKAY);
    int n;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      n++;
    end while (S_AXI_BVALID !== 1'b1 && n < 50);
    chk("bresp", {30'h0, er}, {30'h0, S_AXI_BRESP});
    S_AXI_BREADY <= 1'b0;
    chk("wr_timeout", 32'h0, {31'h0, n >= 50});
    if (n >= 50) wrap_up();
    @(posedge CLK_SYS);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      n++;
    end while (S_AXI_RVALID !== 1'b1 && n < 50);
    d0 = S_AXI_RDATA;
    rr = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    chk("rd_timeout", 32'h0, {31'h0, n >= 50});
    if (n >= 50) wrap_up();
    @(posedge CLK_SYS);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = hlt8_pkg::RESP_OKAY);
    rd(a);
    chk("rdata", e, d0);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask : rc

  initial begin
    {RST_N, SLEEP, ers, xclk, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    foreach (ra[i]) rc(ra[i], {24'h000000, rv[i]});
    wr(r_clk, 8'hFF);
    rc(r_clk, 32'h0000000F);
    wr(8'h1C, 8'h55, hlt8_pkg::RESP_SLVERR);
    rc(8'h1C, 32'h00000000, hlt8_pkg::RESP_SLVERR);
    wr(r_per, 8'h05);
    foreach (pt[i]) begin
      wr(r_ctl, 8'h00);
      wr(r_clk, {4'h0, pt[i][11:8]});
      t = np;
      wr(r_ctl, {1'b1, pt[i][6:4], pt[i][3:0]});
      wait_n(np, t + 3);
      chk("gap", 6 * (2 ** pt[i][7:4]) * (pt[i][3:0] + 1) * (pt[i][11:8] == 4'h0 ? 4 : 1), gap);
    end
    rc(r_sta, 32'h00000001);
    chk("flag", 32'h1, {31'h0, TIMER_INT_FLAG});
    wr(r_ctl, 8'h00);
    rd(r_cnt);
    rc(r_cnt, d0);
    wr(r_sta, 8'h01);
    rc(r_sta, 32'h00000000);
    wr(r_lim, 8'h80);
    wr(r_clk, 8'h01);
    wr(r_per, 8'hFF);
    wr(r_ctl, 8'h80);
    SLEEP <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    rd(r_cnt);
    rc(r_cnt, d0);
    rc(r_per, 32'h000000FF);
    SLEEP <= 1'b0;
    wr(r_ctl, 8'h00);
    wr(r_lim, 8'h00);
    wr(r_clk, 8'h03);
    wr(r_cnt, 8'h00);
    wr(r_ctl, 8'h80);
    chk("keep", 32'h1, {31'h0, OSC_KEEP_ALIVE});
    // External source: rising edges count, falling ones not, then swapped
    xclk <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    rc(r_cnt, 32'h00000001);
    xclk <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    rc(r_cnt, 32'h00000001);
    wr(r_ctl, 8'h00);
    wr(r_lim, 8'h40);
    wr(r_ctl, 8'h80);
    xclk <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    rc(r_cnt, 32'h00000001);
    xclk <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    rc(r_cnt, 32'h00000002);
    wr(r_clk, 8'h01);
    wr(r_per, 8'd100);
    foreach (mm[i]) begin
      wr(r_ctl, 8'h00);
      ers <= mm[i][1];
      wr(r_lim, {3'h0, mm[i]});
      wr(r_ctl, 8'h80);
      s = ns;
      t = np;
      ers <= ~mm[i][1];
      wait_n(ns, s + 1);
      repeat (20) @(posedge CLK_SYS);
      ers <= mm[i][1];
      repeat (10) @(posedge CLK_SYS);
      ers <= ~mm[i][1];
      wait_n(np, t + 1);
      repeat (4) @(posedge CLK_SYS);
      chk("starts", s + 1, ns);
      rc(r_cnt, 32'h00000000);
    end
    wr(r_ctl, 8'h00);
    ers <= 1'b1;
    wr(r_lim, {3'h0, hlt8_pkg::MODE_LVL_HI});
    wr(r_per, 8'h05);
    wr(r_ctl, 8'h80);
    repeat (8) @(posedge CLK_SYS);
    rc(r_cnt, 32'h00000000);
    s = ns;
    t = np;
    ers <= 1'b0;
    wait_n(ns, s + 1);
    wait_n(np, t + 1);
    rc(r_ctl, 32'h00000000);
    rc(r_cnt, 32'h00000000);
    // Input away from the low reset level, so setting enable starts it
    ers <= 1'b1;
    wr(r_lim, {3'h0, hlt8_pkg::MODE_LVL_LO});
    wr(r_ctl, 8'h80);
    wait_n(ns, s + 2);
    wrap_up();
  end
endmodule : hlt8_timer_tb_top
`default_nettype wire
